// file: hw/ext_line_ctrl.sv
/*
  External line trigger controller: edge selection, software trigger, pending
  flags, per-line interrupt and event requests, and a summary interrupt.
  Assumes an AHB-Lite master with word transfers and synchronous line inputs.
*/
// The AHB-Lite interface to the registers was decided locally.
module ext_line_ctrl
  import ext_line_ctrl_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // line sources
  input wire line_vec_t line_in,
  // requests
  output line_vec_t line_irq,
  output line_vec_t line_event,
  output logic irq
);

  ctrl_state_s s;
  ctrl_state_s next_s;

  line_vec_t rise_pulse;
  line_vec_t fall_pulse;
  line_vec_t rise_hit;
  line_vec_t fall_hit;
  line_vec_t soft_pulse;
  line_vec_t soft_clr;
  line_vec_t pend_w1c;
  line_vec_t trig;
  line_vec_t irq_hit;
  logic addr_phase;
  logic wr_now;
  logic rd_status;
  logic [31:0] rd_val;

  line_edge_detect u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .line_in(line_in),
    .rise_pulse(rise_pulse),
    .fall_pulse(fall_pulse)
  );

  always_comb begin
    next_s = s;
    addr_phase = hsel && htrans[1] && hready;
    wr_now = (s.phase == PH_WRITE);
    rise_hit = rise_pulse & s.rise_sel;
    fall_hit = fall_pulse & s.fall_sel;
    soft_pulse = (wr_now && is_reg(s.wr_addr, OFS_SOFT_TRIG)) ? (hwdata & ~s.soft_trig) : '0;
    soft_clr = (wr_now && is_reg(s.wr_addr, OFS_SOFT_TRIG)) ? ~hwdata : '0;
    pend_w1c = (wr_now && is_reg(s.wr_addr, OFS_PENDING)) ? hwdata : '0;
    trig = rise_hit | fall_hit | soft_pulse;
    irq_hit = trig & s.irq_unmask;
    rd_status = 1'b0;
    rd_val = '0;

    // data phase of a write
    if (wr_now) begin
      case (s.wr_addr)
        OFS_IRQ_UNMASK: begin
          next_s.irq_unmask = hwdata;
        end
        OFS_EV_UNMASK: begin
          next_s.ev_unmask = hwdata;
        end
        OFS_RISE_SEL: begin
          next_s.rise_sel = hwdata;
        end
        OFS_FALL_SEL: begin
          next_s.fall_sel = hwdata;
        end
        OFS_SOFT_TRIG: begin
          next_s.soft_trig = hwdata;
        end
        OFS_IRQ_MASK: begin
          next_s.irq_mask = hwdata;
        end
        default: begin
        end
      endcase
    end

    next_s.pending = (s.pending & ~pend_w1c) | trig;
    // clearing a flag also drops its soft request
    next_s.soft_trig = next_s.soft_trig & ~pend_w1c;
    next_s.line_event = trig & s.ev_unmask;

    next_s.phase = PH_IDLE;
    if (addr_phase) begin
      next_s.wr_addr = haddr[ADDR_W-1:0];
      // sub-word writes are dropped
      if (hwrite && hsize == HSIZE_WORD) begin
        next_s.phase = PH_WRITE;
      end
      if (!hwrite) begin
        case (haddr[ADDR_W-1:0])
          OFS_IRQ_UNMASK: begin
            rd_val = next_s.irq_unmask;
          end
          OFS_EV_UNMASK: begin
            rd_val = next_s.ev_unmask;
          end
          OFS_RISE_SEL: begin
            rd_val = next_s.rise_sel;
          end
          OFS_FALL_SEL: begin
            rd_val = next_s.fall_sel;
          end
          OFS_SOFT_TRIG: begin
            rd_val = next_s.soft_trig;
          end
          OFS_PENDING: begin
            rd_val = next_s.pending;
          end
          OFS_IRQ_STATUS: begin
            rd_val = s.irq_status;
            rd_status = 1'b1;
          end
          OFS_IRQ_MASK: begin
            rd_val = next_s.irq_mask;
          end
          default: begin
            rd_val = '0;
          end
        endcase
        next_s.hrdata = rd_val;
      end
    end

    // read clears, a same-cycle event survives
    next_s.irq_status = (rd_status ? '0 : s.irq_status) | irq_hit;
    next_s.after_rst = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s.phase <= PH_IDLE;
      s.wr_addr <= '0;
      s.irq_unmask <= RST_CTRL;
      s.ev_unmask <= RST_CTRL;
      s.rise_sel <= RST_CTRL;
      s.fall_sel <= RST_CTRL;
      s.soft_trig <= RST_CTRL;
      s.pending <= RST_PENDING;
      s.irq_status <= RST_CTRL;
      s.irq_mask <= RST_CTRL;
      s.line_event <= RST_CTRL;
      s.hrdata <= RST_RDATA;
      s.after_rst <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = s.hrdata;
  assign line_irq = s.pending & s.irq_unmask;
  assign line_event = s.line_event;
  assign irq = |(s.irq_status & s.irq_mask);

  // helpers for checks
  line_vec_t ign_fall;
  line_vec_t ign_rise;
  line_vec_t clr_only;
  line_vec_t keep_bits;
  line_vec_t ev_hit;
  logic pend_wr;
  assign ign_fall = fall_pulse & ~s.fall_sel & ~s.pending & ~soft_pulse;
  assign ign_rise = rise_pulse & ~s.rise_sel & ~s.pending & ~soft_pulse;
  assign clr_only = pend_w1c & ~trig;
  assign keep_bits = ~pend_w1c;
  assign ev_hit = trig & s.ev_unmask;
  assign pend_wr = wr_now && is_reg(s.wr_addr, OFS_PENDING);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_fall_taken;
    (fall_hit != '0) |=> ((s.pending & $past(fall_hit)) == $past(fall_hit));
  endproperty
  a_fall_taken: assert property (p_fall_taken) else $error("selected falling edge not pending");

  property p_fall_ignored;
    (ign_fall != '0) |=> ((s.pending & $past(ign_fall)) == '0);
  endproperty
  a_fall_ignored: assert property (p_fall_ignored) else $error("unselected falling edge became pending");

  property p_rise_ignored;
    (ign_rise != '0) |=> ((s.pending & $past(ign_rise)) == '0);
  endproperty
  a_rise_ignored: assert property (p_rise_ignored) else $error("unselected rising edge became pending");

  property p_soft_sets;
    (soft_pulse != '0) |=> ((s.pending & $past(soft_pulse)) == $past(soft_pulse)) &&
      ((s.soft_trig & $past(soft_pulse)) == $past(soft_pulse));
  endproperty
  a_soft_sets: assert property (p_soft_sets) else $error("soft trigger did not set pending");

  property p_soft_clear;
    (soft_clr != '0) |=> ((s.soft_trig & $past(soft_clr)) == '0);
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft trigger bit not withdrawn");

  property p_w1c;
    (clr_only != '0) |=> ((s.pending & $past(clr_only)) == '0);
  endproperty
  a_w1c: assert property (p_w1c) else $error("pending flag not cleared by write one");

  property p_pend_keep;
    pend_wr |=> ((s.pending & $past(keep_bits)) == (($past(s.pending) | $past(trig)) & $past(keep_bits))) &&
      ((s.pending & $past(trig)) == $past(trig));
  endproperty
  a_pend_keep: assert property (p_pend_keep) else $error("pending flag lost on write");

  property p_no_spurious;
    (trig == '0 && !pend_wr) |=> (s.pending == $past(s.pending));
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("pending changed without trigger");

  property p_reset_zero;
    !s.after_rst |-> (s.fall_sel == '0) && (s.soft_trig == '0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("control not zero after reset");

  property p_irq_path;
    (irq_hit != '0) |=> ((s.irq_status & $past(irq_hit)) == $past(irq_hit)) ##0
      (((s.irq_status & s.irq_mask) != '0) == irq);
  endproperty
  a_irq_path: assert property (p_irq_path) else $error("unmasked line did not reach interrupt status");

  property p_event_path;
    (ev_hit != '0) |=> (line_event == $past(ev_hit)) ##1 (line_event == $past(ev_hit));
  endproperty
  a_event_path: assert property (p_event_path) else $error("event output does not follow unmasked trigger");

  property p_rise_taken;
    (rise_hit != '0) |=> ((s.pending & $past(rise_hit)) == $past(rise_hit));
  endproperty
  a_rise_taken: assert property (p_rise_taken) else $error("selected rising edge not pending");

  property p_event_masked;
    ((trig & ~s.ev_unmask) != '0) |=> ((line_event & $past(trig & ~s.ev_unmask)) == '0);
  endproperty
  a_event_masked: assert property (p_event_masked) else $error("masked line reached event output");

  property p_irq_masked;
    ((trig & ~s.irq_unmask & ~s.irq_status) != '0) |=>
      ((s.irq_status & $past(trig & ~s.irq_unmask & ~s.irq_status)) == '0);
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked line reached interrupt status");

  property p_fall_single;
    (fall_pulse != '0) |=> ((fall_pulse & $past(fall_pulse)) == '0);
  endproperty
  a_fall_single: assert property (p_fall_single) else $error("falling edge flag longer than one cycle");

  property p_rise_single;
    (rise_pulse != '0) |=> ((rise_pulse & $past(rise_pulse)) == '0);
  endproperty
  a_rise_single: assert property (p_rise_single) else $error("rising edge flag longer than one cycle");

  c_soft: cover property ((soft_pulse != '0) ##1 (line_irq != '0));
  c_fall: cover property ((fall_hit != '0) ##1 (line_event != '0));
  c_irq: cover property ($rose(irq));
  c_clear: cover property ((clr_only != '0) ##1 (s.pending == '0));
  c_rise: cover property ((rise_hit != '0) ##1 (line_irq != '0));

endmodule

// file: hw/ext_line_ctrl_pkg.sv
/*
  Constants, register map and state types for the external line trigger block.
  Assumes a single 100 MHz bus clock and an AHB-Lite slave window of 256 bytes.
*/
package ext_line_ctrl_pkg;

  localparam int unsigned NUM_LINES = 32;
  localparam int unsigned ADDR_W = 8;

  typedef logic [NUM_LINES-1:0] line_vec_t;
  typedef logic [ADDR_W-1:0] reg_addr_t;

  // register byte offsets
  localparam reg_addr_t OFS_IRQ_UNMASK = 8'h00;
  localparam reg_addr_t OFS_EV_UNMASK = 8'h04;
  localparam reg_addr_t OFS_RISE_SEL = 8'h08;
  localparam reg_addr_t OFS_FALL_SEL = 8'h0C;
  localparam reg_addr_t OFS_SOFT_TRIG = 8'h10;
  localparam reg_addr_t OFS_PENDING = 8'h14;
  localparam reg_addr_t OFS_IRQ_STATUS = 8'h18;
  localparam reg_addr_t OFS_IRQ_MASK = 8'h1C;

  // values after reset
  localparam line_vec_t RST_CTRL = 32'h00000000;
  localparam line_vec_t RST_PENDING = 32'h00000000;
  localparam logic [31:0] RST_RDATA = 32'h00000000;

  // bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_WRITE = 1'b1
  } bus_phase_e;

  typedef struct packed {
    bus_phase_e phase;
    reg_addr_t wr_addr;
    line_vec_t irq_unmask;
    line_vec_t ev_unmask;
    line_vec_t rise_sel;
    line_vec_t fall_sel;
    line_vec_t soft_trig;
    line_vec_t pending;
    line_vec_t irq_status;
    line_vec_t irq_mask;
    line_vec_t line_event;
    logic [31:0] hrdata;
    logic after_rst;
  } ctrl_state_s;

  typedef struct packed {
    line_vec_t sample;
    line_vec_t prev;
    logic primed1;
    logic primed2;
  } edge_state_s;

  // exact match of a word-aligned register offset
  function automatic logic is_reg(input reg_addr_t addr, input reg_addr_t ofs);
    is_reg = (addr == ofs);
  endfunction

endpackage

// file: hw/line_edge_detect.sv
/*
  Per-line edge detector: samples every line on the clock and flags changes.
  Assumes line inputs are already synchronous to hclk.
*/
module line_edge_detect
  import ext_line_ctrl_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // lines
  input wire line_vec_t line_in,
  // one-cycle edge flags
  output line_vec_t rise_pulse,
  output line_vec_t fall_pulse
);

  edge_state_s s;
  edge_state_s next_s;

  always_comb begin
    next_s = s;
    next_s.sample = line_in;
    next_s.prev = s.sample;
    next_s.primed1 = 1'b1;
    next_s.primed2 = s.primed1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // no edge until two samples exist
  assign rise_pulse = s.primed2 ? (s.sample & ~s.prev) : '0;
  assign fall_pulse = s.primed2 ? (~s.sample & s.prev) : '0;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_edge_history;
    s.primed2 |-> (rise_pulse == ($past(line_in) & ~$past(line_in, 2))) &&
      (fall_pulse == (~$past(line_in) & $past(line_in, 2)));
  endproperty
  a_edge_history: assert property (p_edge_history) else $error("edge flag does not match line history");

endmodule

// file: sim/ext_line_ctrl_bench.sv
/*
  Self-checking bench for the external line trigger block: ahb-lite master
  tasks, line source model and register level scenarios.
  Assumes a single slave, so hready is the block's own hreadyout.
*/
module ext_line_ctrl_bench
  import ext_line_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  line_vec_t line_in;
  line_vec_t line_irq;
  line_vec_t line_event;
  logic irq;
  line_vec_t ev_seen = 32'h00000000;
  logic [31:0] ev_cnt = 32'h00000000;
  int errors = 0;
  int n_checks = 0;

  always #5 hclk = ~hclk;

  ext_line_ctrl DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .line_in(line_in),
    .line_irq(line_irq), .line_event(line_event), .irq(irq)
  );

  line_source_model lines (
    .hclk(hclk),
    .line_in(line_in)
  );

  // collects one-cycle event pulses so they are not missed
  always @(posedge hclk) begin
    if (hresetn && line_event !== 32'h00000000) begin
      ev_seen <= ev_seen | line_event;
      ev_cnt <= ev_cnt + 32'h00000001;
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single word transfer; read data taken at the end of the data phase
  task automatic bus(input logic wr_en, input reg_addr_t a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr_en;
    hsize <= HSIZE_WORD;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task automatic wr(input reg_addr_t a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input reg_addr_t a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    chk_word(r, exp);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // cut a hang; the scenarios need well under a thousand cycles
  initial begin
    #100000;
    errors++;
    test_done();
  end

  initial begin
    wait_cyc(2);
    hresetn <= 1'b1;
    wait_cyc(1);
    rd_chk(OFS_FALL_SEL, 32'h00000000);
    rd_chk(OFS_SOFT_TRIG, 32'h00000000);
    chk_bit(hresp, HRESP_OKAY);
    chk_bit(hreadyout, 1'b1);
    wr(OFS_PENDING, 32'hFFFFFFFF);
    wr(OFS_FALL_SEL, 32'hA5A55A5A);
    rd_chk(OFS_FALL_SEL, 32'hA5A55A5A);
    rd_chk(8'h40, 32'h00000000);
    wr(OFS_FALL_SEL, 32'h00000008);
    wr(OFS_EV_UNMASK, 32'h00000028);
    wr(OFS_IRQ_UNMASK, 32'h00000030);
    // lines 3 and 4 fall, only line 3 selected
    lines.drive(32'h000000E7);
    wait_cyc(6);
    rd_chk(OFS_PENDING, 32'h00000008);
    chk_word(ev_seen, 32'h00000008);
    chk_word(ev_cnt, 32'h00000001);
    wr(OFS_PENDING, 32'h00000000);
    rd_chk(OFS_PENDING, 32'h00000008);
    wr(OFS_PENDING, 32'h00000008);
    rd_chk(OFS_PENDING, 32'h00000000);
    // both rise, only line 4 selected for rising edges
    wr(OFS_RISE_SEL, 32'h00000010);
    lines.drive(32'h000000FF);
    wait_cyc(6);
    rd_chk(OFS_PENDING, 32'h00000010);
    chk_word(line_irq, 32'h00000010);
    chk_word(ev_seen, 32'h00000008);
    chk_bit(irq, 1'b0);
    wr(OFS_SOFT_TRIG, 32'h00000020);
    wait_cyc(2);
    rd_chk(OFS_SOFT_TRIG, 32'h00000020);
    rd_chk(OFS_PENDING, 32'h00000030);
    chk_word(ev_seen, 32'h00000028);
    chk_word(ev_cnt, 32'h00000002);
    chk_word(line_irq, 32'h00000030);
    wr(OFS_IRQ_MASK, 32'h00000020);
    wait_cyc(2);
    chk_bit(irq, 1'b1);
    rd_chk(OFS_IRQ_STATUS, 32'h00000030);
    wait_cyc(2);
    chk_bit(irq, 1'b0);
    rd_chk(OFS_IRQ_STATUS, 32'h00000000);
    wr(OFS_SOFT_TRIG, 32'h00000000);
    rd_chk(OFS_SOFT_TRIG, 32'h00000000);
    wr(OFS_PENDING, 32'h00000020);
    rd_chk(OFS_PENDING, 32'h00000010);
    wr(OFS_SOFT_TRIG, 32'h00000020);
    wait_cyc(2);
    rd_chk(OFS_PENDING, 32'h00000030);
    chk_word(ev_cnt, 32'h00000003);
    chk_bit(irq, 1'b1);
    // falling edge with the select bit cleared leaves no trace
    wr(OFS_FALL_SEL, 32'h00000000);
    lines.drive(32'h000000F7);
    wait_cyc(6);
    rd_chk(OFS_PENDING, 32'h00000030);
    chk_word(ev_cnt, 32'h00000003);
    test_done();
  end
endmodule

// file: sim/line_source_model.sv
/*
  Model of the line sources in front of the trigger block: pin lines and
  wakeup signals, held as plain levels.
  Assumes the lines are synchronous to hclk and change just after a rising edge.
*/
module line_source_model
  import ext_line_ctrl_pkg::*;
(
  // clock
  input wire logic hclk,
  // lines to the block
  output line_vec_t line_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // low byte high through reset, so no edge is seen at release
  initial line_in = 32'h000000FF;

  task automatic drive(input line_vec_t v);
    @(posedge hclk);
    line_in <= v;
  endtask
endmodule
